// file: hw/uia_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "uia_defines.svh"

module uia_top
   import uia_pkg::*;
#(
   parameter int ADR_W = 8,
   parameter int ERR_W = `UIA_ERR_W
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // usb engine event pulses
   input  wire logic [6:0]       status_evt_i,
   input  wire logic [ERR_W-1:0] error_evt_i,
   // processor interrupt side
   output logic                  usb_combined_irq_flag_o,
   output logic                  irq_o
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic        comb;
      logic        irq;
   } uia_top_state_t;

   uia_top_state_t state_ff;
   uia_top_state_t nxt_state;

   // ************************************************************
   // register outputs
   // ************************************************************
   logic [`UIA_STAT_W-1:0] status_irq_flag_reg;
   logic [`UIA_STAT_W-1:0] status_irq_enable_reg;
   logic [ERR_W-1:0]       error_irq_flag_reg;
   logic [ERR_W-1:0]       error_irq_enable_reg;
   logic [0:0]             irq_mask_reg;

   // ************************************************************
   // bus decode
   // ************************************************************
   logic                   req;
   logic                   wr_req;
   logic                   rd_req;
   uia_sel_t               sel;
   logic [7:0]             wbyte;
   logic                   wr_stat_en;
   logic                   wr_err_en;
   logic                   wr_mask;
   logic [`UIA_STAT_W-1:0] stat_clr;
   logic [ERR_W-1:0]       err_clr;
   logic [`UIA_STAT_W-1:0] stat_set;
   logic                   top_error_flag;
   logic [7:0]             peripheral_irq_flags_2;

   // new request only while ack is low, so each access acts once
   assign req    = wb_cyc_i & wb_stb_i & ~state_ff.ack;
   assign wr_req = req & wb_we_i;
   assign rd_req = req & ~wb_we_i;
   assign wbyte  = wb_dat_i[7:0];

   always_comb begin
      case ({wb_adr_i[ADR_W-1:2], 2'b00})
         ADR_W'(`UIA_OFS_STAT_FLAG): sel = UIA_SEL_STAT_FLAG;
         ADR_W'(`UIA_OFS_STAT_EN):   sel = UIA_SEL_STAT_EN;
         ADR_W'(`UIA_OFS_ERR_FLAG):  sel = UIA_SEL_ERR_FLAG;
         ADR_W'(`UIA_OFS_ERR_EN):    sel = UIA_SEL_ERR_EN;
         ADR_W'(`UIA_OFS_PERIPHERAL_IRQ_FLAGS_2):      sel = UIA_SEL_PERIPHERAL_IRQ_FLAGS_2;
         ADR_W'(`UIA_OFS_IRQ_MASK):  sel = UIA_SEL_IRQ_MASK;
         default:                    sel = UIA_SEL_NONE;
      endcase
   end

   assign wr_stat_en = wr_req & (sel == UIA_SEL_STAT_EN) & wb_sel_i[0];
   assign wr_err_en  = wr_req & (sel == UIA_SEL_ERR_EN) & wb_sel_i[0];
   assign wr_mask    = wr_req & (sel == UIA_SEL_IRQ_MASK) & wb_sel_i[0];

   // read of a flag register clears what it returned
   assign stat_clr = (rd_req && sel == UIA_SEL_STAT_FLAG) ? '1 : '0;
   assign err_clr  = (rd_req && sel == UIA_SEL_ERR_FLAG) ? '1 : '0;

   // ************************************************************
   // flag layers
   // ************************************************************
   // error enable gates an error up into the status layer
   assign top_error_flag = status_evt_i[`UIA_BIT_TOP_ERROR]
                         | (|(error_evt_i & error_irq_enable_reg));

   always_comb begin
      stat_set                     = status_evt_i;
      stat_set[`UIA_BIT_TOP_ERROR] = top_error_flag;
   end

   uia_flag_bank #(
      .W (`UIA_STAT_W)
   ) u_stat_flags (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (stat_set),
      .clr_i  (stat_clr),
      .flag_o (status_irq_flag_reg)
   );

   uia_flag_bank #(
      .W (ERR_W)
   ) u_err_flags (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .set_i  (error_evt_i),
      .clr_i  (err_clr),
      .flag_o (error_irq_flag_reg)
   );

   // ************************************************************
   // enable and mask registers
   // ************************************************************
   uia_ctl_reg #(
      .W   (`UIA_STAT_W),
      .RST (`UIA_RST_STAT_EN)
   ) u_stat_en (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .wr_i   (wr_stat_en),
      .wdat_i (wbyte[`UIA_STAT_W-1:0]),
      .q_o    (status_irq_enable_reg)
   );

   uia_ctl_reg #(
      .W   (ERR_W),
      .RST (ERR_W'(`UIA_RST_ERR_EN))
   ) u_err_en (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .wr_i   (wr_err_en),
      .wdat_i (ERR_W'(wb_dat_i)),
      .q_o    (error_irq_enable_reg)
   );

   uia_ctl_reg #(
      .W   (1),
      .RST (`UIA_RST_IRQ_MASK)
   ) u_mask (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .wr_i   (wr_mask),
      .wdat_i (wb_dat_i[`UIA_BIT_COMBINED]),
      .q_o    (irq_mask_reg)
   );

   // ************************************************************
   // combined request and bus answer
   // ************************************************************
   always_comb begin
      peripheral_irq_flags_2                    = 8'h00;
      peripheral_irq_flags_2[`UIA_BIT_COMBINED] = state_ff.comb;
   end

   always_comb begin
      nxt_state     = state_ff;
      // enabled flags only; drops once none remain
      nxt_state.comb = |(status_irq_flag_reg & status_irq_enable_reg);
      nxt_state.irq  = nxt_state.comb & irq_mask_reg[0];
      nxt_state.ack  = req;
      if (rd_req) begin
         case (sel)
            UIA_SEL_STAT_FLAG: nxt_state.dat = 32'(status_irq_flag_reg);
            UIA_SEL_STAT_EN:   nxt_state.dat = 32'(status_irq_enable_reg);
            UIA_SEL_ERR_FLAG:  nxt_state.dat = 32'(error_irq_flag_reg);
            UIA_SEL_ERR_EN:    nxt_state.dat = 32'(error_irq_enable_reg);
            UIA_SEL_PERIPHERAL_IRQ_FLAGS_2:      nxt_state.dat = 32'(peripheral_irq_flags_2);
            UIA_SEL_IRQ_MASK:  nxt_state.dat = 32'({irq_mask_reg, 4'h0});
            default:           nxt_state.dat = 32'h0000_0000;
         endcase
      end else if (req) begin
         nxt_state.dat = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign wb_ack_o                = state_ff.ack;
   assign wb_dat_o                = state_ff.dat;
   assign usb_combined_irq_flag_o = state_ff.comb;
   assign irq_o                   = state_ff.irq;

endmodule

`default_nettype wire

// file: hw/uia_defines.svh
`ifndef UIA_DEFINES_SVH
`define UIA_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define UIA_OFS_STAT_FLAG   8'h00
`define UIA_OFS_STAT_EN     8'h04
`define UIA_OFS_ERR_FLAG    8'h08
`define UIA_OFS_ERR_EN      8'h0C
`define UIA_OFS_PERIPHERAL_IRQ_FLAGS_2        8'h10
`define UIA_OFS_IRQ_MASK    8'h14

// ************************************************************
// field positions
// ************************************************************
`define UIA_STAT_W          7
`define UIA_BIT_FRAME_START 6
`define UIA_BIT_STALL       5
`define UIA_BIT_IDLE        4
`define UIA_BIT_TRN_DONE    3
`define UIA_BIT_BUS_ACT     2
`define UIA_BIT_TOP_ERROR   1
`define UIA_BIT_BUS_RESET   0
`define UIA_BIT_COMBINED    4
`define UIA_ERR_W           8

// ************************************************************
// reset values
// ************************************************************
`define UIA_RST_STAT_EN     7'h00
`define UIA_RST_ERR_EN      8'h00
`define UIA_RST_IRQ_MASK    1'h0

`endif

// file: hw/uia_pkg.sv
package uia_pkg;

   typedef logic [31:0] uia_word_t;

   // register selected by a bus address
   typedef enum {
      UIA_SEL_STAT_FLAG,
      UIA_SEL_STAT_EN,
      UIA_SEL_ERR_FLAG,
      UIA_SEL_ERR_EN,
      UIA_SEL_PERIPHERAL_IRQ_FLAGS_2,
      UIA_SEL_IRQ_MASK,
      UIA_SEL_NONE
   } uia_sel_t;

   // low byte lane merge: only byte lane 0 carries register bits
   function automatic logic [7:0] uia_lane0(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       sel0);
      uia_lane0 = sel0 ? new_v : old_v;
   endfunction

endpackage

// file: hw/uia_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none

module uia_flag_bank #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // set and clear strobes
   input  wire logic [W-1:0] set_i,
   input  wire logic [W-1:0] clr_i,
   // sticky flags
   output logic      [W-1:0] flag_o
);

   typedef struct packed {
      logic [W-1:0] flg;
   } uia_fb_state_t;

   uia_fb_state_t state_ff;
   uia_fb_state_t nxt_state;

   always_comb begin
      nxt_state     = state_ff;
      // set beats a clear in the same cycle
      nxt_state.flg = (state_ff.flg & ~clr_i) | set_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign flag_o = state_ff.flg;

endmodule

`default_nettype wire

// file: hw/uia_ctl_reg.sv
`timescale 1ns/1ps
`default_nettype none

module uia_ctl_reg #(
   parameter int         W   = 8,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // write port
   input  wire logic         wr_i,
   input  wire logic [W-1:0] wdat_i,
   // stored value
   output logic      [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] val;
   } uia_cr_state_t;

   uia_cr_state_t state_ff;
   uia_cr_state_t nxt_state;

   always_comb begin
      nxt_state = state_ff;
      if (wr_i) begin
         nxt_state.val = wdat_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign q_o = state_ff.val;

endmodule

`default_nettype wire

// file: sim/uia_checker.sv
`timescale 1ns/1ps
`default_nettype none
module uia_checker #(
   parameter int ADR_W = 8,
   parameter int ERR_W = 8
) (
   // watched ports
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic [6:0]       status_evt_i,
   input wire logic [ERR_W-1:0] error_evt_i,
   input wire logic             usb_combined_irq_flag_o,
   input wire logic             irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   write_data_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
      else $error("data on write ack");
   unmapped_read_a: assert property (wb_ack_o && $past(wb_adr_i[ADR_W-1:2]) > 5
      |-> wb_dat_o == 32'h0000_0000) else $error("unmapped data not zero");
   enable_top_a: assert property (wb_ack_o && $past(wb_adr_i[ADR_W-1:2] == 1)
      |-> wb_dat_o[31:7] == 25'h000_0000) else $error("enable upper bits set");
   peripheral_irq_flags_2_bit_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[ADR_W-1:2] == 4)
      |-> wb_dat_o == (32'h0000_0010 & {32{$past(usb_combined_irq_flag_o)}}))
      else $error("combined bit read wrong");
   irq_gate_a: assert property (irq_o |-> usb_combined_irq_flag_o)
      else $error("irq without combined");
   comb_rise_a: assert property ($rose(usb_combined_irq_flag_o) |->
      $past(status_evt_i, 2) != 0 || $past(error_evt_i, 2) != 0 ||
      $past(error_evt_i, 3) != 0 || $past(wb_ack_o && wb_we_i)) else $error("combined rose");
   comb_fall_a: assert property ($fell(usb_combined_irq_flag_o) |-> $past(wb_ack_o))
      else $error("combined fell without access");
   cover property ($rose(irq_o));
   cover property ($fell(usb_combined_irq_flag_o));
   cover property (error_evt_i != 0);
endmodule
`default_nettype wire

// file: sim/uia_sie_model.sv
`timescale 1ns/1ps
`default_nettype none
module uia_sie_model (
   // command
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [6:0] st_i,
   input  wire logic [7:0] er_i,
   // event pulses
   output logic      [6:0] status_evt_o,
   output logic      [7:0] error_evt_o
);
   // one-cycle pulses, quiet otherwise
   always_ff @(posedge clk_i) begin
      status_evt_o <= go_i ? st_i : 7'h00;
      error_evt_o  <= go_i ? er_i : 8'h00;
   end
endmodule
`default_nettype wire

// file: sim/uia_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "uia_defines.svh"
module uia_top_test;
   logic        clk_i, rst_i, cyc, stb, we, ack, go, comb, irq;
   logic [7:0]  adr, er, eevt;
   logic [6:0]  st, sevt;
   logic [31:0] wdat, rdat, q;
   int          error_cnt, tests_run;
   uia_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .status_evt_i(sevt), .error_evt_i(eevt), .usb_combined_irq_flag_o(comb), .irq_o(irq));
   uia_sie_model sie (.clk_i(clk_i), .go_i(go), .st_i(st), .er_i(er),
      .status_evt_o(sevt), .error_evt_o(eevt));
   // *****
   // tasks
   // *****
   task automatic results;
      if (error_cnt == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("MISMATCH %s exp %h got %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      // request stands until ack is sampled high at a rising edge
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(n, e, q);
   endtask
   task automatic pulse(input logic [6:0] s, input logic [7:0] r);
      go <= 1'b1;
      st <= s;
      er <= r;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic t_reset;
      rd("stat_en", `UIA_OFS_STAT_EN, 32'h0000_0000);
      rd("err_en", `UIA_OFS_ERR_EN, 32'h0000_0000);
      rd("mask", `UIA_OFS_IRQ_MASK, 32'h0000_0000);
      rd("peripheral_irq_flags_2", `UIA_OFS_PERIPHERAL_IRQ_FLAGS_2, 32'h0000_0000);
      chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
   endtask
   task automatic t_enable;
      wb(1'b1, `UIA_OFS_STAT_EN, 32'hFFFF_FFFF);
      rd("stat_en", `UIA_OFS_STAT_EN, 32'h0000_007F);
      wb(1'b1, `UIA_OFS_STAT_EN, 32'h0000_0000);
      rd("stat_en", `UIA_OFS_STAT_EN, 32'h0000_0000);
   endtask
   task automatic t_midreset;
      wb(1'b1, `UIA_OFS_STAT_EN, 32'h0000_0001);
      pulse(7'h01, 8'h00);
      chk("comb", 32'h0000_0001, {31'h0000_0000, comb});
      chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
      wb(1'b1, `UIA_OFS_IRQ_MASK, 32'h0000_0010);
      rd("mask", `UIA_OFS_IRQ_MASK, 32'h0000_0010);
      chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
      // reset in mid-run clears flags, enables and mask
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("comb", 32'h0000_0000, {31'h0000_0000, comb});
      chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
      rd("stat_en", `UIA_OFS_STAT_EN, 32'h0000_0000);
      rd("mask", `UIA_OFS_IRQ_MASK, 32'h0000_0000);
      rd("stat_flag", `UIA_OFS_STAT_FLAG, 32'h0000_0000);
   endtask
   task automatic t_poll;
      for (int i = 0; i < 7; i++) begin
         pulse(7'h01 << i, 8'h00);
         chk("comb", 32'h0000_0000, {31'h0000_0000, comb});
         rd("stat_flag", `UIA_OFS_STAT_FLAG, 32'h0000_0001 << i);
         rd("stat_flag", `UIA_OFS_STAT_FLAG, 32'h0000_0000);
      end
   endtask
   task automatic t_gate;
      wb(1'b1, `UIA_OFS_STAT_EN, 32'h0000_0008);
      wb(1'b1, `UIA_OFS_IRQ_MASK, 32'h0000_0010);
      pulse(7'h20, 8'h00);
      chk("comb", 32'h0000_0000, {31'h0000_0000, comb});
      pulse(7'h08, 8'h00);
      chk("comb", 32'h0000_0001, {31'h0000_0000, comb});
      chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
      rd("peripheral_irq_flags_2", `UIA_OFS_PERIPHERAL_IRQ_FLAGS_2, 32'h0000_0010);
      rd("stat_flag", `UIA_OFS_STAT_FLAG, 32'h0000_0028);
      chk("comb", 32'h0000_0000, {31'h0000_0000, comb});
      chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
      wb(1'b1, `UIA_OFS_STAT_EN, 32'h0000_0000);
   endtask
   task automatic t_error;
      wb(1'b1, `UIA_OFS_ERR_EN, 32'h0000_0001);
      rd("err_en", `UIA_OFS_ERR_EN, 32'h0000_0001);
      pulse(7'h00, 8'h81);
      rd("err_flag", `UIA_OFS_ERR_FLAG, 32'h0000_0081);
      rd("stat_flag", `UIA_OFS_STAT_FLAG, 32'h0000_0002);
      rd("err_flag", `UIA_OFS_ERR_FLAG, 32'h0000_0000);
      rd("unmapped", 8'h1C, 32'h0000_0000);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      error_cnt++;
      results();
   end
   initial begin
      {cyc, stb, we, go, adr, er, st, wdat} = '0;
      error_cnt = 0;
      tests_run = 0;
      rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_enable();
      t_midreset();
      t_poll();
      t_gate();
      t_error();
      results();
   end
endmodule
bind uia_top uia_checker #(.ADR_W(ADR_W), .ERR_W(ERR_W)) chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .status_evt_i(status_evt_i), .error_evt_i(error_evt_i),
   .usb_combined_irq_flag_o(usb_combined_irq_flag_o), .irq_o(irq_o));
`default_nettype wire
